// ===== common/acg_pkg.sv
// adc clock generation package: register map, field layout, reset values,
// clock source encoding and the bus request carrier.
// assumes a single 40 MHz system clock that also serves as bus clock.
package acg_pkg;

   // *******************************************************************
   // register bus
   // *******************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } acg_bus_req_t;

   localparam logic [ADDR_W-1:0] OFS_CTRL1  = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_SECOND_CONTROL_REGISTER  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_POWER  = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h3;

   // first control register fields
   localparam int BIT_START_A  = 0;
   localparam int BIT_START_B  = 1;
   localparam int POS_MODE     = 2;
   localparam int BIT_SIMULTANEOUS_SELECT   = 4;
   // scan mode: bit 0 parallel, bit 1 loop
   localparam int MODE_W       = 2;
   localparam int MODE_PAR_BIT = 0;
   localparam int MODE_LOOP_BIT = 1;

   // second control register: conversion clock divisor
   localparam int POS_DIV = 0;
   localparam int DIV_W   = 4;

   // power register fields
   localparam int BIT_PD0     = 0;
   localparam int BIT_PD1     = 1;
   localparam int BIT_APD     = 2;
   localparam int BIT_ASB     = 3;
   localparam int POS_POWER_UP_DELAY_COUNT = 4;
   localparam int PUD_W       = 6;

   // status register fields
   localparam int BIT_ACT_A  = 0;
   localparam int BIT_ACT_B  = 1;
   localparam int BIT_PSTS0  = 2;
   localparam int BIT_PSTS1  = 3;
   localparam int POS_SRC    = 4;

   // reset values
   localparam logic [MODE_W-1:0] RST_MODE    = 2'h0;
   localparam logic [DIV_W-1:0]  RST_DIV     = 4'h0;
   localparam logic [PUD_W-1:0]  RST_POWER_UP_DELAY_COUNT = 6'h0D;

   // *******************************************************************
   // timing
   // *******************************************************************
   localparam int MCLK_PERIOD_NS = 25;
   // fastest adc clock period in system clocks, split into two halves
   localparam int ADC_MIN_PERIOD_SYS = 6;
   localparam int HALF_W             = 5;
   localparam logic [HALF_W-1:0] CONV_HALF_BASE =
      HALF_W'(ADC_MIN_PERIOD_SYS / 2 - 1);
   // standby clock: oscillator divided 80:1, toggled every 40 edges
   localparam int STBY_RATIO  = 80;
   localparam int STBY_W      = 6;
   localparam logic [STBY_W-1:0] STBY_HALF = STBY_W'(STBY_RATIO / 2 - 1);

   // *******************************************************************
   // adc clock source
   // *******************************************************************
   typedef enum logic [1:0] {
      ACG_SRC_OFF  = 2'b00,
      ACG_SRC_CONV = 2'b01,
      ACG_SRC_STBY = 2'b10
   } acg_src_t;

endpackage

// ===== rtl/acg_div.sv
// acg_div: restartable tick divider; one tick per half+1 enabled cycles.
// assumes en and restart are synchronous to clk.
`timescale 1ns/1ps
module acg_div #(
   parameter int W = 5
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         en,
   input  wire logic         restart,
   input  wire logic [W-1:0] half,
   output logic              tick
);
   logic [W-1:0] cnt;

   // compare with >= so a smaller divisor never strands the counter;
   // restart does not gate tick, so no loop runs back through restart
   assign tick = en && (cnt >= half);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
      end else if (restart || tick) begin
         cnt <= '0;
      end else if (en) begin
         cnt <= cnt + W'(1);
      end
   end
endmodule

// ===== rtl/acg_pud.sv
// acg_pud: power-up delay timer counted in adc clock rising edges.
// assumes adc_rise is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module acg_pud
   import acg_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic             trigger,
   input  wire logic [PUD_W-1:0] delay,
   input  wire logic             adc_rise,
   output logic                  busy,
   output logic                  done
);
   logic [PUD_W-1:0] cnt;

   assign done = busy && (cnt == '0) && !trigger;

   // delay value is captured when the power-up begins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt  <= '0;
         busy <= 1'b0;
      end else if (trigger) begin
         cnt  <= delay;
         busy <= 1'b1;
      end else if (done) begin
         busy <= 1'b0;
      end else if (busy && adc_rise) begin
         cnt <= cnt - PUD_W'(1);
      end
   end
endmodule

// ===== rtl/acg_top.sv
// acg_top: adc clock generation, source selection and start resync.
// assumes scan-done pulses from the converters are synchronous to mclk;
// sync inputs and the 8 MHz oscillator come from pins.
//
// Functional notes
// [RULE_01] conversion clock drives the converters whenever a scan runs
// [RULE_02] conversion clock is the bus clock divided by the divisor field; the code divides by 2*(clock_divisor+3)
// [RULE_03] software keeps the conversion clock between 100 kHz and 5 MHz
// [RULE_04] software changes no clock or power setting while powered up
// [RULE_05] loop scan or normal power mode keeps the adc clock running
// [RULE_06] adc clock runs throughout every power-up delay
// [RULE_07] auto modes stop the clock after the scan completes
// [RULE_08] standby clock is the 8 MHz oscillator divided by eighty
// [RULE_09] auto standby with both converters idle selects standby clock
// [RULE_10] system supplies an 8 MHz oscillator for auto standby
// [RULE_11] fastest adc clock period spans six system clocks
// [RULE_12] a scan start restarts the adc clock phase and begins at once
// [RULE_13] sequential and simultaneous modes launch both from one start
// [RULE_14] non-simultaneous parallel uses own start bit and sync input
// [RULE_15] later converter waits for the next adc clock rising edge
// [RULE_16] software may align the second start with an adc clock edge
// [RULE_17] starts are ignored while the power-up delay is running
// [RULE_18] source switches leave no runt or truncated clock phase
// [RULE_19] delay counts adc clocks, value taken when power-up begins
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module acg_top (
   input  wire logic                  mclk,
   input  wire logic                  nrst,
   input  wire acg_pkg::acg_bus_req_t bus_req,
   output logic [acg_pkg::DATA_W-1:0] bus_rdata,
   input  wire logic                  scan_sync_input_a,
   input  wire logic                  scan_sync_input_b,
   input  wire logic                  osc_8mhz,
   input  wire logic                  converter_a_scan_done,
   input  wire logic                  converter_b_scan_done,
   output logic                       adc_clk,
   output logic                       converter_a_start,
   output logic                       converter_b_start,
   output logic                       converter_a_power_on,
   output logic                       converter_b_power_on,
   output logic [1:0]                 adc_clk_source
);
   import acg_pkg::*;

   // *******************************************************************
   // registers
   // *******************************************************************
   logic [MODE_W-1:0] scan_mode;
   logic              simultaneous_select;
   logic [DIV_W-1:0]  clock_divisor;
   logic              converter0_power_down;
   logic              converter1_power_down;
   logic              auto_power_down;
   logic              auto_standby;
   logic [PUD_W-1:0]  power_up_delay_count;

   logic wr_ctrl1;
   logic wr_second_control_register;
   logic wr_power;
   logic start_wr_a;
   logic start_wr_b;

   assign wr_ctrl1   = bus_req.wr && (bus_req.addr == OFS_CTRL1);
   assign wr_second_control_register   = bus_req.wr && (bus_req.addr == OFS_SECOND_CONTROL_REGISTER);
   assign wr_power   = bus_req.wr && (bus_req.addr == OFS_POWER);
   // start bits are write-one strobes and read back as zero
   assign start_wr_a = wr_ctrl1 && bus_req.wdata[BIT_START_A];
   assign start_wr_b = wr_ctrl1 && bus_req.wdata[BIT_START_B];

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scan_mode           <= RST_MODE;
         simultaneous_select <= 1'b0;
      end else if (wr_ctrl1) begin
         scan_mode           <= bus_req.wdata[POS_MODE +: MODE_W];
         simultaneous_select <= bus_req.wdata[BIT_SIMULTANEOUS_SELECT];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         clock_divisor <= RST_DIV;
      end else if (wr_second_control_register) begin
         clock_divisor <= bus_req.wdata[POS_DIV +: DIV_W];
      end
   end

   // converters come out of reset powered down
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         converter0_power_down <= 1'b1;
         converter1_power_down <= 1'b1;
         auto_power_down       <= 1'b0;
         auto_standby          <= 1'b0;
         power_up_delay_count  <= RST_POWER_UP_DELAY_COUNT;
      end else if (wr_power) begin
         converter0_power_down <= bus_req.wdata[BIT_PD0];
         converter1_power_down <= bus_req.wdata[BIT_PD1];
         auto_power_down       <= bus_req.wdata[BIT_APD];
         auto_standby          <= bus_req.wdata[BIT_ASB];
         power_up_delay_count  <= bus_req.wdata[POS_POWER_UP_DELAY_COUNT +: PUD_W];
      end
   end

   // *******************************************************************
   // pin synchronisers and edge detection
   // *******************************************************************
   logic [1:0] sync_a_meta;
   logic [1:0] sync_b_meta;
   logic [1:0] osc_meta;
   logic [1:0] sync_a_q;
   logic [1:0] sync_b_q;
   logic [1:0] osc_q;
   logic       sync_a_rise;
   logic       sync_b_rise;
   logic       osc_rise;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sync_a_meta <= 2'h0;
         sync_b_meta <= 2'h0;
         osc_meta    <= 2'h0;
         sync_a_q    <= 2'h0;
         sync_b_q    <= 2'h0;
         osc_q       <= 2'h0;
      end else begin
         sync_a_meta <= {sync_a_meta[0], scan_sync_input_a};
         sync_b_meta <= {sync_b_meta[0], scan_sync_input_b};
         osc_meta    <= {osc_meta[0], osc_8mhz};
         sync_a_q    <= {sync_a_q[0], sync_a_meta[1]};
         sync_b_q    <= {sync_b_q[0], sync_b_meta[1]};
         osc_q       <= {osc_q[0], osc_meta[1]};
      end
   end

   assign sync_a_rise = sync_a_q[0] && !sync_a_q[1];
   assign sync_b_rise = sync_b_q[0] && !sync_b_q[1];
   assign osc_rise    = osc_q[0] && !osc_q[1];

   // *******************************************************************
   // clock dividers
   // *******************************************************************
   acg_src_t         src;
   acg_src_t         next_src;
   logic             conv_tick;
   logic             stby_tick;
   logic             conv_restart;
   logic             stby_restart;
   logic             resync;
   logic             switch_ok;
   logic             cur_tick;
   logic             adc_rise;
   logic [HALF_W-1:0] conv_half;

   // [RULE_02] [RULE_11] divisor sets half period
   assign conv_half = CONV_HALF_BASE + HALF_W'(clock_divisor);

   acg_div #(.W(HALF_W)) u_conv_div (
      .clk     (mclk),
      .nrst    (nrst),
      .en      (1'b1),
      .restart (conv_restart),
      .half    (conv_half),
      .tick    (conv_tick)
   );

   // [RULE_08] eighty to one standby
   acg_div #(.W(STBY_W)) u_stby_div (
      .clk     (mclk),
      .nrst    (nrst),
      .en      (osc_rise),
      .restart (stby_restart),
      .half    (STBY_HALF),
      .tick    (stby_tick)
   );

   assign cur_tick = (src == ACG_SRC_CONV) ? conv_tick :
                     (src == ACG_SRC_STBY) ? stby_tick : 1'b0;
   assign adc_rise = cur_tick && !adc_clk;

   // *******************************************************************
   // per-converter scan control
   // *******************************************************************
   logic par_mode;
   logic loop_mode;
   logic shared_start;
   logic auto_mode;
   logic req_a;
   logic req_b;
   logic accept_a;
   logic accept_b;
   logic wait_a;
   logic wait_b;
   logic pend_a;
   logic pend_b;
   logic active_a;
   logic active_b;
   logic launch_a;
   logic launch_b;
   logic both_idle;
   logic pd0_q;
   logic pd1_q;
   logic pud_go_a;
   logic pud_go_b;
   logic busy_a;
   logic busy_b;
   logic done_a;
   logic done_b;

   assign par_mode     = scan_mode[MODE_PAR_BIT];
   assign loop_mode    = scan_mode[MODE_LOOP_BIT];
   assign auto_mode    = auto_power_down || auto_standby;
   assign shared_start = !par_mode || simultaneous_select;
   assign both_idle    = !active_a && !active_b;

   // [RULE_13] one start launches both
   // [RULE_14] independent starts otherwise
   assign req_a = start_wr_a || sync_a_rise;
   assign req_b = shared_start ? req_a : (start_wr_b || sync_b_rise);

   // [RULE_17] ignore start while powering
   assign accept_a = req_a && !converter0_power_down && !busy_a &&
                     !wait_a && !pend_a && !active_a;
   assign accept_b = req_b && !converter1_power_down && !busy_b &&
                     !wait_b && !pend_b && !active_b;

   // [RULE_19] delay starts on power-up or activation
   assign pud_go_a = (pd0_q && !converter0_power_down) ||
                     (accept_a && auto_mode);
   assign pud_go_b = (pd1_q && !converter1_power_down) ||
                     (accept_b && auto_mode);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pd0_q <= 1'b1;
         pd1_q <= 1'b1;
      end else begin
         pd0_q <= converter0_power_down;
         pd1_q <= converter1_power_down;
      end
   end

   acg_pud u_pud_a (
      .clk      (mclk),
      .nrst     (nrst),
      .trigger  (pud_go_a),
      .delay    (power_up_delay_count),
      .adc_rise (adc_rise),
      .busy     (busy_a),
      .done     (done_a)
   );

   acg_pud u_pud_b (
      .clk      (mclk),
      .nrst     (nrst),
      .trigger  (pud_go_b),
      .delay    (power_up_delay_count),
      .adc_rise (adc_rise),
      .busy     (busy_b),
      .done     (done_b)
   );

   // [RULE_12] first start resyncs at once
   // [RULE_15] later start waits for rising edge
   assign launch_a = pend_a && (src == ACG_SRC_CONV) &&
                     (both_idle || adc_rise);
   assign launch_b = pend_b && (src == ACG_SRC_CONV) &&
                     (both_idle || adc_rise);
   assign resync   = (launch_a || launch_b) && both_idle;

   // auto modes wait out the delay before the scan is launched
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wait_a <= 1'b0;
         wait_b <= 1'b0;
      end else begin
         wait_a <= (accept_a && auto_mode) || (wait_a && !done_a);
         wait_b <= (accept_b && auto_mode) || (wait_b && !done_b);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pend_a <= 1'b0;
         pend_b <= 1'b0;
      end else begin
         pend_a <= (accept_a && !auto_mode) || (wait_a && done_a) ||
                   (pend_a && !launch_a);
         pend_b <= (accept_b && !auto_mode) || (wait_b && done_b) ||
                   (pend_b && !launch_b);
      end
   end

   // a launch in the same cycle as a completion keeps the scan active
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         active_a <= 1'b0;
         active_b <= 1'b0;
      end else begin
         active_a <= launch_a || (active_a && !converter_a_scan_done);
         active_b <= launch_b || (active_b && !converter_b_scan_done);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         converter_a_start <= 1'b0;
         converter_b_start <= 1'b0;
      end else begin
         converter_a_start <= launch_a;
         converter_b_start <= launch_b;
      end
   end

   // auto power-down keeps converters off while idle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         converter_a_power_on <= 1'b0;
         converter_b_power_on <= 1'b0;
      end else begin
         converter_a_power_on <= !converter0_power_down &&
            (!auto_power_down || busy_a || wait_a || pend_a || active_a);
         converter_b_power_on <= !converter1_power_down &&
            (!auto_power_down || busy_b || wait_b || pend_b || active_b);
      end
   end

   // *******************************************************************
   // adc clock source selection
   // *******************************************************************
   logic powered_any;
   logic need_conv;

   assign powered_any = !converter0_power_down || !converter1_power_down;

   // [RULE_01] [RULE_05] [RULE_06] [RULE_07] conversion clock demand
   assign need_conv = active_a || active_b || busy_a || busy_b ||
                      wait_a || wait_b || pend_a || pend_b ||
                      (powered_any && (loop_mode || !auto_mode));

   // [RULE_09] standby when idle
   always_comb begin
      if (need_conv) begin
         next_src = ACG_SRC_CONV;
      end else if (powered_any && auto_standby && !auto_power_down) begin
         next_src = ACG_SRC_STBY;
      end else begin
         next_src = ACG_SRC_OFF;
      end
   end

   // [RULE_18] switch at once from off, otherwise only at a falling edge
   assign switch_ok = (next_src != src) &&
                      ((src == ACG_SRC_OFF) || (cur_tick && adc_clk));

   assign conv_restart = resync ||
                         (switch_ok && (next_src == ACG_SRC_CONV));
   assign stby_restart = switch_ok && (next_src == ACG_SRC_STBY);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         src <= ACG_SRC_OFF;
      end else if (switch_ok) begin
         src <= next_src;
      end
   end

   // a resync restarts the phase counter, stretching the current phase
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         adc_clk <= 1'b0;
      end else if (switch_ok) begin
         adc_clk <= 1'b0;
      end else if (cur_tick) begin
         adc_clk <= !adc_clk;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         adc_clk_source <= 2'h0;
      end else begin
         adc_clk_source <= switch_ok ? next_src : src;
      end
   end

   // *******************************************************************
   // read port
   // *******************************************************************
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            OFS_CTRL1: begin
               next_rdata[POS_MODE +: MODE_W] = scan_mode;
               next_rdata[BIT_SIMULTANEOUS_SELECT]         = simultaneous_select;
            end
            OFS_SECOND_CONTROL_REGISTER: begin
               next_rdata[POS_DIV +: DIV_W] = clock_divisor;
            end
            OFS_POWER: begin
               next_rdata[BIT_PD0]                = converter0_power_down;
               next_rdata[BIT_PD1]                = converter1_power_down;
               next_rdata[BIT_APD]                = auto_power_down;
               next_rdata[BIT_ASB]                = auto_standby;
               next_rdata[POS_POWER_UP_DELAY_COUNT +: PUD_W]   = power_up_delay_count;
            end
            OFS_STATUS: begin
               next_rdata[BIT_ACT_A]  = active_a;
               next_rdata[BIT_ACT_B]  = active_b;
               next_rdata[BIT_PSTS0]  = busy_a;
               next_rdata[BIT_PSTS1]  = busy_b;
               next_rdata[POS_SRC +: 2] = src;
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         bus_rdata <= '0;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

endmodule

// ===== testbench/acg_top_props.sv
// acg_top_props: checks on the adc clock and launch outputs.
// assumes it is bound into acg_top; one clock domain.
`timescale 1ns/1ps
module acg_top_props
   import acg_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       adc_clk,
   input  wire logic       converter_a_start,
   input  wire logic       converter_b_start,
   input  wire logic [1:0] adc_clk_source
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ****************************************************************
   // assertions
   // ****************************************************************
   start_pulse_a: assert property (
      converter_a_start |=> !converter_a_start) else $error("long start");
   start_clk_a: assert property (
      converter_a_start || converter_b_start |->
      adc_clk_source == ACG_SRC_CONV) else $error("start off conversion");
   conv_high_a: assert property (
      $rose(adc_clk) && adc_clk_source == ACG_SRC_CONV |-> adc_clk [*3])
      else $error("short high phase");
   clk_low_a: assert property (
      $fell(adc_clk) |-> !adc_clk [*3]) else $error("short low phase");
   src_switch_a: assert property (
      $changed(adc_clk_source) |-> !adc_clk) else $error("switch on high");
   off_low_a: assert property (
      adc_clk_source == ACG_SRC_OFF |-> !adc_clk) else $error("clock off");
   stby_high_a: assert property (
      $rose(adc_clk) && adc_clk_source == ACG_SRC_STBY |-> adc_clk [*8])
      else $error("short standby phase");
   src_legal_a: assert property (
      adc_clk_source != 2'h3) else $error("bad source");
   cover property (converter_a_start && converter_b_start);
   cover property (converter_b_start && !converter_a_start);
   cover property ($rose(adc_clk) && adc_clk_source == ACG_SRC_STBY);
endmodule
bind acg_top acg_top_props u_props (.mclk, .nrst, .adc_clk,
   .converter_a_start, .converter_b_start, .adc_clk_source);

// ===== testbench/acg_conv_model.sv
// acg_conv_model: converter that ends a scan after LEN adc clock rises.
// assumes start and scan_done are synchronous to mclk.
`timescale 1ns/1ps
module acg_conv_model #(
   parameter int LEN = 4
) (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic adc_clk,
   input  wire logic start,
   output logic      scan_done
);
   logic prev;
   logic busy;
   int   cnt;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prev      <= 1'b0;
         busy      <= 1'b0;
         cnt       <= 0;
         scan_done <= 1'b0;
      end else begin
         prev      <= adc_clk;
         scan_done <= 1'b0;
         if (start) begin
            busy <= 1'b1;
            cnt  <= 0;
         end else if (busy && adc_clk && !prev) begin
            busy      <= cnt != LEN - 1;
            scan_done <= cnt == LEN - 1;
            cnt       <= cnt + 1;
         end
      end
   end
endmodule

// ===== testbench/test_acg_top.sv
// test_acg_top: directed scenarios for adc clock generation.
// assumes two converter models and a free 8 MHz oscillator.
`timescale 1ns/1ps
module test_acg_top;
   import acg_pkg::*;
   logic         mclk = 0, nrst = 0, osc_8mhz = 0;
   logic         scan_sync_input_a = 0, scan_sync_input_b = 0;
   acg_bus_req_t bus_req = '0;
   logic [15:0]  bus_rdata;
   logic         adc_clk, converter_a_start, converter_b_start;
   logic         converter_a_power_on, converter_b_power_on;
   logic         converter_a_scan_done, converter_b_scan_done;
   logic [1:0]   adc_clk_source;
   int           fail_count = 0, samples_checked = 0, na = 0, nb = 0;
   always #12.5 mclk = ~mclk;
   always #62.5 osc_8mhz = ~osc_8mhz;
   always @(posedge mclk) begin
      if (converter_a_start === 1'b1) na <= na + 1;
      if (converter_b_start === 1'b1) nb <= nb + 1;
   end
   acg_top DUT (.mclk, .nrst, .bus_req, .bus_rdata, .scan_sync_input_a,
      .scan_sync_input_b, .osc_8mhz, .converter_a_scan_done,
      .converter_b_scan_done, .adc_clk, .converter_a_start,
      .converter_b_start, .converter_a_power_on, .converter_b_power_on,
      .adc_clk_source);
   acg_conv_model conv_a (.mclk, .nrst, .adc_clk,
      .start(converter_a_start), .scan_done(converter_a_scan_done));
   acg_conv_model conv_b (.mclk, .nrst, .adc_clk,
      .start(converter_b_start), .scan_done(converter_b_scan_done));
   task chk(input string name, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk) bus_req.wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge mclk) bus_req <= '{a, 16'h0, 1'b0, 1'b1};
      @(posedge mclk) bus_req.rd <= 1'b0;
      #1 v = bus_rdata;
   endtask
   task wait_st(input logic [15:0] m);
      logic [15:0] v;
      v = m;
      for (int n = 0; n < 300 && (v & m) != 0; n++) rd(OFS_STATUS, v);
      chk("status", v & m, 16'h0);
   endtask
   task rise(output int n);
      logic p;
      n = 0;
      p = adc_clk;
      while (n < 400 && !(adc_clk === 1'b1 && p === 1'b0)) begin
         p = adc_clk;
         @(posedge mclk);
         #1 n++;
      end
   endtask
   task t_reset;
      logic [15:0] v;
      rd(OFS_POWER, v);
      chk("power", v, 16'h00D3);
      rd(OFS_SECOND_CONTROL_REGISTER, v);
      chk("divisor", v, 16'h0000);
      rd(4'hF, v);
      chk("unmapped", v, 16'h0000);
      chk("source", 16'(adc_clk_source), 16'h0);
      chk("on a", 16'(converter_a_power_on), 16'h0);
      chk("on b", 16'(converter_b_power_on), 16'h0);
   endtask
   task t_normal(input logic [3:0] d);
      int n, a0;
      wr(OFS_POWER, 16'h00D3);
      wr(OFS_CTRL1, 16'h0000);
      wr(OFS_SECOND_CONTROL_REGISTER, {12'h0, d});
      wr(OFS_POWER, 16'h00D0);
      a0 = na;
      wr(OFS_CTRL1, 16'h0001);
      wait_st(16'h000C);
      chk("early start", 16'(na - a0), 16'h0);
      chk("on a", 16'(converter_a_power_on), 16'h1);
      chk("on b", 16'(converter_b_power_on), 16'h1);
      rise(n);
      rise(n);
      chk("period", 16'(n), 16'(2 * (d + 3)));
      chk("source", 16'(adc_clk_source), 16'(ACG_SRC_CONV));
      wr(OFS_CTRL1, 16'h0001);
      @(posedge mclk);
      #1 chk("start a", 16'(converter_a_start), 16'h1);
      chk("start b", 16'(converter_b_start), 16'h1);
      wait_st(16'h0003);
   endtask
   task t_parallel;
      int n, a0, b0;
      wr(OFS_POWER, 16'h00D3);
      wr(OFS_CTRL1, 16'h0004);
      wr(OFS_POWER, 16'h00D0);
      wait_st(16'h000C);
      a0 = na;
      b0 = nb;
      wr(OFS_CTRL1, 16'h0006);
      @(posedge mclk);
      #1 chk("start b", 16'(converter_b_start), 16'h1);
      // second start timed from an adc clock rise
      rise(n);
      @(posedge mclk) scan_sync_input_a <= 1'b1;
      repeat (4) @(posedge mclk);
      scan_sync_input_a <= 1'b0;
      for (n = 0; n < 40 && na == a0; n++) @(posedge mclk);
      #1 chk("late a", 16'(na - a0), 16'h1);
      chk("b once", 16'(nb - b0), 16'h1);
      wait_st(16'h0003);
   endtask
   task t_standby;
      int n, a0;
      wr(OFS_POWER, 16'h00D3);
      wr(OFS_CTRL1, 16'h0000);
      wr(OFS_POWER, 16'h00D8);
      wait_st(16'h000C);
      for (n = 0; n < 600 && adc_clk_source !== 2'h2; n++) @(posedge mclk);
      #1 chk("idle", 16'(adc_clk_source), 16'(ACG_SRC_STBY));
      a0 = na;
      wr(OFS_CTRL1, 16'h0001);
      for (n = 0; n < 900 && na == a0; n++) @(posedge mclk);
      #1 chk("auto start", 16'(na - a0), 16'h1);
      for (n = 0; n < 900 && adc_clk_source !== 2'h2; n++) @(posedge mclk);
      #1 chk("back", 16'(adc_clk_source), 16'(ACG_SRC_STBY));
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      t_reset;
      t_normal(4'h0);
      t_normal(4'h2);
      t_parallel;
      t_standby;
      end_of_test;
   end
   initial begin
      #(25 * 20000);
      fail_count++;
      end_of_test;
   end
endmodule
